// File: common/dcu_if.sv
// Purpose: two-wire link plus strobe, reset and address select pins
// Assumes: data line is open drain with a pull-up
// Notes:   clock line is driven push-pull by the controller only
`default_nettype none

interface dcu_if;
	logic scl;
	logic sda;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic load_strobe_n;
	logic reset_n;
	logic address_select_pin;

	// wired-and of both drivers, pull-up when nobody drives
	assign sda = (host_sda_oe ? host_sda_o : 1'h1) & (dev_sda_oe ? dev_sda_o : 1'h1);

	modport device (
		input  scl,
		input  sda,
		input  load_strobe_n,
		input  reset_n,
		input  address_select_pin,
		output dev_sda_o,
		output dev_sda_oe
	);

	modport host (
		input  sda,
		output scl,
		output host_sda_o,
		output host_sda_oe,
		output load_strobe_n,
		output reset_n,
		output address_select_pin
	);
endinterface : dcu_if

`default_nettype wire

// File: common/dcu_pkg.sv
// Purpose: shared constants and types for the converter control link
// Assumes: one 125 MHz system clock at both ends
// Notes:   field positions, defaults and timing counts live only here
`default_nettype none

package dcu_pkg;
	// clock
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned CLK_HZ        = 125_000_000;

	// target address, upper five bits then select pin then fixed lsb
	localparam logic [4:0] ADDR_HI  = 5'h13;
	localparam logic       ADDR_LSB = 1'h0;

	// command nibble codes
	localparam logic [3:0] CMD_NOP     = 4'h0;
	localparam logic [3:0] CMD_WR_IN   = 4'h1;
	localparam logic [3:0] CMD_LOAD    = 4'h2;
	localparam logic [3:0] CMD_WR_BOTH = 4'h3;
	localparam logic [3:0] CMD_WR_CTRL = 4'h4;

	// control word field positions
	localparam int unsigned CTL_SWRST_POS  = 15;
	localparam int unsigned CTL_PWDN_HI    = 14;
	localparam int unsigned CTL_PWDN_LO    = 13;
	localparam int unsigned CTL_REFDIS_POS = 12;
	localparam int unsigned CTL_GAIN_POS   = 11;

	// power-down select encodings
	localparam logic [1:0] PWDN_NORMAL = 2'h0;
	localparam logic [1:0] PWDN_1K     = 2'h1;
	localparam logic [1:0] PWDN_100K   = 2'h2;
	localparam logic [1:0] PWDN_TRI    = 2'h3;

	// register defaults
	localparam logic [15:0] CODE_RST   = 16'h0000;
	localparam logic [1:0]  PWDN_RST   = 2'h0;
	localparam logic        REFDIS_RST = 1'h0;
	localparam logic        GAIN_RST   = 1'h0;

	// timing
	localparam int unsigned PD_EXIT_NS      = 4000;
	localparam int unsigned PD_EXIT_CYC     = (PD_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PD_EXIT_REF_US  = 600;
	localparam int unsigned PD_EXIT_REF_CYC = (PD_EXIT_REF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RSTPIN_MIN_NS   = 75;
	localparam int unsigned RSTPIN_CYC      = (RSTPIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SCL_HZ          = 400_000;
	localparam int unsigned SCL_QTR_CYC     = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

	// link pin bundle indices, idle levels
	localparam int unsigned PIN_SCL  = 0;
	localparam int unsigned PIN_SDA  = 1;
	localparam int unsigned PIN_LOAD = 2;
	localparam int unsigned PIN_RST  = 3;
	localparam int unsigned PIN_ASEL = 4;
	localparam logic [4:0]  PIN_IDLE = 5'h0F;

	// controller register offsets and fields
	localparam logic [3:0]  HREG_CTRL     = 4'h0;
	localparam logic [3:0]  HREG_DATA     = 4'h4;
	localparam logic [3:0]  HREG_PINS     = 4'h8;
	localparam logic [3:0]  HREG_STAT     = 4'hC;
	localparam int unsigned HCTL_WRITE    = 0;
	localparam int unsigned HCTL_READ     = 1;
	localparam int unsigned HCTL_RSTPULSE = 2;
	localparam int unsigned HPIN_LOAD     = 0;
	localparam int unsigned HPIN_ASEL     = 1;
	localparam int unsigned HPIN_ASYNC    = 2;
	localparam int unsigned HPIN_SAVE     = 3;
	localparam logic [3:0]  HPINS_RST     = 4'h1;

	typedef enum logic [2:0] {
		DS_IDLE  = 3'h0,
		DS_ADDR  = 3'h1,
		DS_WRITE = 3'h2,
		DS_READ  = 3'h3,
		DS_SKIP  = 3'h4
	} dcu_dev_state_e;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'h0,
		HS_START = 2'h1,
		HS_BIT   = 2'h2,
		HS_STOP  = 2'h3
	} dcu_host_state_e;
endpackage : dcu_pkg

`default_nettype wire

// File: hdl/dcu_device.sv
// Purpose: converter target: serial decode, code registers, control word
// Assumes: link pins sampled on sys_clk_i; link is far slower than clock
// Notes:   analog side is represented by registered code and mode outputs
// Notes on behaviour
// - load command copies input code to active
// - write-both loads active and input together
// - control bits: reset, two power-down, ref, gain
// - gain bit selects single or double span
// - reference disable bit, default enabled
// - host disables reference when powering down
// - power-down pair selects load or three-state
// - power-down keeps active code, still updatable
// - power-down exit settles 4 or 600 us
// - software reset restores defaults, self clears
// - read returns input register as two bytes
// - controller ends read with nack, stop
// - load strobe copies input to active
// - strobe low during write updates all
// - async style: strobe falls after stop
// - strobe pulse during own transfer ignored
// - reset pin forces defaults, held 75 ns
// - output stays zero until reprogrammed
// - commands ignored while reset pin low
// - reference start waits for reset release
// - command nibble decode of five commands
// - write: address, command, two data bytes
// - address 10011, select pin, then zero
`default_nettype none

module dcu_device
	import dcu_pkg::*;
#(
	parameter int unsigned EXIT_REF_CYC = PD_EXIT_REF_CYC
)
(
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	dcu_if.device            link,
	output var  logic [15:0] analog_output_code_o,
	output var  logic        span_x2_o,
	output var  logic        ref_on_o,
	output var  logic        powerdown_sel_hi_o,
	output var  logic        powerdown_sel_lo_o,
	output var  logic        output_driven_o,
	output var  logic        load_1k_o,
	output var  logic        load_100k_o,
	output var  logic        output_valid_o
);
	localparam logic [16:0] EXIT_CNT     = 17'(PD_EXIT_CYC);
	localparam logic [16:0] EXIT_REF_CNT = 17'(EXIT_REF_CYC);

	logic [4:0]     pin_s1_reg;
	logic [4:0]     pin_s2_reg;
	logic [4:0]     pin_s3_reg;
	logic [4:0]     pin_f_reg;
	logic [4:0]     pin_fd_reg;
	dcu_dev_state_e state_reg;
	logic [3:0]     bitc_reg;
	logic           byte_reg;
	logic [1:0]     widx_reg;
	logic [7:0]     sh_reg;
	logic [7:0]     tx_reg;
	logic [7:0]     hi_reg;
	logic [3:0]     cmd_reg;
	logic [15:0]    data_reg;
	logic           exec_reg;
	logic           rd_reg;
	logic           mack_reg;
	logic           busy_reg;
	logic           sda_oe_reg;
	logic [15:0]    input_reg;
	logic [15:0]    active_reg;
	logic [1:0]     pwdn_reg;
	logic           refdis_reg;
	logic           gain_reg;
	logic [16:0]    exit_cnt_reg;

	// pin bundle and change filter; a level counts once stages two and three agree
	wire [4:0] pin_raw   = {link.address_select_pin, link.reset_n, link.load_strobe_n, link.sda, link.scl};
	wire [4:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);

	// edge and condition decode on filtered levels
	wire scl_rise  = pin_f_reg[PIN_SCL] & ~pin_fd_reg[PIN_SCL];
	wire scl_fall  = ~pin_f_reg[PIN_SCL] & pin_fd_reg[PIN_SCL];
	wire scl_high  = pin_f_reg[PIN_SCL] & pin_fd_reg[PIN_SCL];
	wire start_det = scl_high & pin_fd_reg[PIN_SDA] & ~pin_f_reg[PIN_SDA];
	wire stop_det  = scl_high & ~pin_fd_reg[PIN_SDA] & pin_f_reg[PIN_SDA];
	wire load_fall = pin_fd_reg[PIN_LOAD] & ~pin_f_reg[PIN_LOAD];
	wire rst_pin   = ~pin_f_reg[PIN_RST];
	wire clr_all   = ~resetn_i | rst_pin;
	wire sda_bit   = pin_f_reg[PIN_SDA];
	wire bit8      = bitc_reg == 4'h8;
	wire bit9      = bitc_reg == 4'h9;
	wire mid_bit   = (bitc_reg != 4'h0) & (bitc_reg < 4'h8);
	wire addr_hit  = sh_reg[7:1] == {ADDR_HI, pin_f_reg[PIN_ASEL], ADDR_LSB};
	wire [7:0] rd_next = byte_reg ? input_reg[15:8] : input_reg[7:0];
	wire active_bus = (state_reg != DS_IDLE) & (state_reg != DS_SKIP);

	// three-stage sampling of the link pins
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			pin_s1_reg <= PIN_IDLE;
			pin_s2_reg <= PIN_IDLE;
			pin_s3_reg <= PIN_IDLE;
			pin_f_reg  <= PIN_IDLE;
			pin_fd_reg <= PIN_IDLE;
		end
		else
		begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_f_reg  <= (pin_agree & pin_s3_reg) | (~pin_agree & pin_f_reg);
			pin_fd_reg <= pin_f_reg;
		end
	end

	// serial target engine; acts on filtered scl edges
	always_ff @(posedge sys_clk_i)
	begin
		exec_reg <= 1'h0;
		if (clr_all)
		begin
			state_reg  <= DS_IDLE;
			bitc_reg   <= 4'h0;
			byte_reg   <= 1'h0;
			widx_reg   <= 2'h0;
			sh_reg     <= 8'h00;
			tx_reg     <= 8'h00;
			hi_reg     <= 8'h00;
			cmd_reg    <= CMD_NOP;
			data_reg   <= CODE_RST;
			rd_reg     <= 1'h0;
			mack_reg   <= 1'h0;
			busy_reg   <= 1'h0;
			sda_oe_reg <= 1'h0;
		end
		else if (start_det)
		begin
			state_reg  <= DS_ADDR;
			bitc_reg   <= 4'h0;
			busy_reg   <= 1'h0;
			sda_oe_reg <= 1'h0;
		end
		else if (stop_det)
		begin
			state_reg  <= DS_IDLE;
			busy_reg   <= 1'h0;
			sda_oe_reg <= 1'h0;
		end
		else if (scl_rise && active_bus)
		begin
			if (bitc_reg < 4'h8)
				sh_reg <= {sh_reg[6:0], sda_bit};
			else
				mack_reg <= ~sda_bit;
			bitc_reg <= bitc_reg + 4'h1;
		end
		else if (scl_fall && active_bus)
		begin
			case (state_reg)
				DS_ADDR:
				begin
					if (bit8 && addr_hit)
					begin
						sda_oe_reg <= 1'h1;
						busy_reg   <= 1'h1;
						rd_reg     <= sh_reg[0];
					end
					else if (bit8)
						state_reg <= DS_SKIP;
					else if (bit9)
					begin
						bitc_reg <= 4'h0;
						widx_reg <= 2'h0;
						// readback starts with input high byte
						byte_reg   <= 1'h0;
						tx_reg     <= input_reg[15:8];
						sda_oe_reg <= rd_reg & ~input_reg[15];
						state_reg  <= rd_reg ? DS_READ : DS_WRITE;
					end
				end
				DS_WRITE:
				begin
					// command byte then two data bytes, each acked
					if (bit8)
					begin
						sda_oe_reg <= 1'h1;
						widx_reg   <= (widx_reg == 2'h3) ? widx_reg : widx_reg + 2'h1;
						if (widx_reg == 2'h0)
							cmd_reg <= sh_reg[7:4];
						if (widx_reg == 2'h1)
							hi_reg <= sh_reg;
						// act on last falling edge before ack
						if (widx_reg == 2'h2)
						begin
							data_reg <= {hi_reg, sh_reg};
							exec_reg <= 1'h1;
						end
					end
					else if (bit9)
					begin
						sda_oe_reg <= 1'h0;
						bitc_reg   <= 4'h0;
					end
				end
				DS_READ:
				begin
					if (mid_bit)
					begin
						tx_reg     <= {tx_reg[6:0], 1'h0};
						sda_oe_reg <= ~tx_reg[6];
					end
					else if (bit8)
						sda_oe_reg <= 1'h0;
					else if (bit9 && mack_reg)
					begin
						// second byte is the input low byte
						bitc_reg   <= 4'h0;
						byte_reg   <= ~byte_reg;
						tx_reg     <= rd_next;
						sda_oe_reg <= ~rd_next[7];
					end
					else if (bit9)
						state_reg <= DS_SKIP;
				end
				default:
					state_reg <= state_reg;
			endcase
		end
	end

	// code and control registers
	always_ff @(posedge sys_clk_i)
	begin
		if (clr_all)
		begin
			input_reg  <= CODE_RST;
			active_reg <= CODE_RST;
			pwdn_reg   <= PWDN_RST;
			refdis_reg <= REFDIS_RST;
			gain_reg   <= GAIN_RST;
		end
		else if (exec_reg)
		begin
			case (cmd_reg)
				CMD_WR_IN:
				begin
					input_reg <= data_reg;
					// strobe held low loads active too
					if (!pin_f_reg[PIN_LOAD])
						active_reg <= data_reg;
				end
				CMD_LOAD:
					active_reg <= input_reg;
				CMD_WR_BOTH:
				begin
					input_reg  <= data_reg;
					active_reg <= data_reg;
				end
				CMD_WR_CTRL:
				begin
					// software reset, bit is never stored
					if (data_reg[CTL_SWRST_POS])
					begin
						input_reg  <= CODE_RST;
						active_reg <= CODE_RST;
						pwdn_reg   <= PWDN_RST;
						refdis_reg <= REFDIS_RST;
						gain_reg   <= GAIN_RST;
					end
					else
					begin
						pwdn_reg   <= {data_reg[CTL_PWDN_HI], data_reg[CTL_PWDN_LO]};
						refdis_reg <= data_reg[CTL_REFDIS_POS];
						gain_reg   <= data_reg[CTL_GAIN_POS];
					end
				end
				default:
					input_reg <= input_reg;
			endcase
		end
		// hardware strobe, falling edge; not mid-transfer
		else if (load_fall && !busy_reg)
			active_reg <= input_reg;
	end

	// power-down exit settling; reference-off exit is far longer
	always_ff @(posedge sys_clk_i)
	begin
		if (clr_all)
			exit_cnt_reg <= 17'h00000;
		// exit time depends on reference state
		else if (pwdn_reg != PWDN_NORMAL)
			exit_cnt_reg <= refdis_reg ? EXIT_REF_CNT : EXIT_CNT;
		else if (exit_cnt_reg != 17'h00000)
			exit_cnt_reg <= exit_cnt_reg - 17'h00001;
	end

	// registered outputs; active code untouched by power-down
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			analog_output_code_o <= CODE_RST;
			span_x2_o            <= GAIN_RST;
			ref_on_o             <= 1'h0;
			powerdown_sel_hi_o   <= PWDN_RST[1];
			powerdown_sel_lo_o   <= PWDN_RST[0];
			output_driven_o      <= 1'h1;
			load_1k_o            <= 1'h0;
			load_100k_o          <= 1'h0;
			output_valid_o       <= 1'h1;
		end
		else
		begin
			// code kept in power-down; zero until programmed
			analog_output_code_o <= active_reg;
			span_x2_o <= gain_reg;
			// reference on unless disabled; waits for pin release
			ref_on_o           <= ~refdis_reg & ~rst_pin;
			powerdown_sel_hi_o <= pwdn_reg[1];
			powerdown_sel_lo_o <= pwdn_reg[0];
			output_driven_o <= pwdn_reg == PWDN_NORMAL;
			load_1k_o       <= pwdn_reg == PWDN_1K;
			load_100k_o     <= pwdn_reg == PWDN_100K;
			output_valid_o  <= (pwdn_reg == PWDN_NORMAL) & (exit_cnt_reg == 17'h00000);
		end
	end

	// open-drain data pin: only ever pulls low
	assign link.dev_sda_o  = 1'h0;
	assign link.dev_sda_oe = sda_oe_reg;
endmodule : dcu_device

`default_nettype wire

// File: hdl/dcu_host.sv
// Purpose: bus controller and pin driver for the converter target
// Assumes: software reaches it by address, data, write and read strobes
// Notes:   clock line derived here by a quarter-period divider
`default_nettype none

module dcu_host
	import dcu_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output var  logic [31:0] rdata_o,
	dcu_if.host              link
);
	localparam logic [6:0] QTR_LAST = 7'(SCL_QTR_CYC - 1);
	localparam logic [3:0] RST_LEN  = 4'(RSTPIN_CYC);

	dcu_host_state_e state_reg;
	logic [6:0]      qcnt_reg;
	logic [1:0]      ph_reg;
	logic [3:0]      bitn_reg;
	logic [1:0]      idx_reg;
	logic [7:0]      sh_reg;
	logic [15:0]     rx_reg;
	logic [23:0]     txd_reg;
	logic [3:0]      pins_reg;
	logic            rd_reg;
	logic            nack_reg;
	logic            busy_reg;
	logic [3:0]      rst_cnt_reg;
	logic [2:0]      sda_s_reg;
	logic            sda_f_reg;
	logic            scl_reg;
	logic            sda_oe_reg;
	logic            load_n_reg;
	logic            rst_n_reg;
	logic            asel_reg;

	// bus slave decode
	wire wr_ctrl  = wr_i & (addr_i == HREG_CTRL) & ~busy_reg & (rst_cnt_reg == 4'h0);
	wire go_write = wr_ctrl & wdata_i[HCTL_WRITE];
	wire go_read  = wr_ctrl & ~wdata_i[HCTL_WRITE] & wdata_i[HCTL_READ];
	wire [31:0] stat_word = {rx_reg, 14'h0000, nack_reg, busy_reg};
	wire tick     = qcnt_reg == QTR_LAST;
	wire last_idx = idx_reg == (rd_reg ? 2'h2 : 2'h3);
	wire rx_byte  = rd_reg & (idx_reg != 2'h0);
	wire [7:0] tx_next = (idx_reg == 2'h0) ? txd_reg[23:16] : (idx_reg == 2'h1) ? txd_reg[15:8] : txd_reg[7:0];
	// optional: power-down control write also disables reference
	wire save_ref = pins_reg[HPIN_SAVE] & (wdata_i[23:20] == CMD_WR_CTRL)
		& (wdata_i[CTL_PWDN_HI] | wdata_i[CTL_PWDN_LO]);

	// register writes, readback and data line sampling
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			txd_reg   <= 24'h000000;
			pins_reg  <= HPINS_RST;
			rdata_o   <= 32'h00000000;
			sda_s_reg <= 3'h7;
			sda_f_reg <= 1'h1;
		end
		else
		begin
			sda_s_reg <= {sda_s_reg[1:0], link.sda};
			if (sda_s_reg[1] == sda_s_reg[2])
				sda_f_reg <= sda_s_reg[2];
			if (wr_i && addr_i == HREG_DATA)
				txd_reg <= wdata_i[23:0] | {11'h000, save_ref, 12'h000};
			if (wr_i && addr_i == HREG_PINS)
				pins_reg <= wdata_i[3:0];
			if (rd_i && addr_i == HREG_STAT)
				rdata_o <= stat_word;
			else if (rd_i && addr_i == HREG_DATA)
				rdata_o <= {8'h00, txd_reg};
			else if (rd_i && addr_i == HREG_PINS)
				rdata_o <= {28'h0000000, pins_reg};
			else
				rdata_o <= 32'h00000000;
		end
	end

	// pin drivers and reset pulse
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			rst_cnt_reg <= 4'h0;
			rst_n_reg   <= 1'h1;
			load_n_reg  <= 1'h1;
			asel_reg    <= 1'h0;
		end
		else
		begin
			// reset pin low for at least the minimum width
			if (wr_ctrl && wdata_i[HCTL_RSTPULSE] && !wdata_i[HCTL_WRITE] && !wdata_i[HCTL_READ])
				rst_cnt_reg <= RST_LEN;
			else if (rst_cnt_reg != 4'h0)
				rst_cnt_reg <= rst_cnt_reg - 4'h1;
			rst_n_reg <= ~(wr_ctrl & wdata_i[HCTL_RSTPULSE] & ~wdata_i[HCTL_WRITE] & ~wdata_i[HCTL_READ])
				& (rst_cnt_reg <= 4'h1);
			// async style keeps strobe high through the transfer
			load_n_reg <= pins_reg[HPIN_LOAD] | (pins_reg[HPIN_ASYNC] & busy_reg);
			asel_reg   <= pins_reg[HPIN_ASEL];
		end
	end

	// quarter-bit divider and byte engine
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			state_reg  <= HS_IDLE;
			qcnt_reg   <= 7'h00;
			ph_reg     <= 2'h0;
			bitn_reg   <= 4'h0;
			idx_reg    <= 2'h0;
			sh_reg     <= 8'h00;
			rx_reg     <= 16'h0000;
			rd_reg     <= 1'h0;
			nack_reg   <= 1'h0;
			busy_reg   <= 1'h0;
			scl_reg    <= 1'h1;
			sda_oe_reg <= 1'h0;
		end
		else if (state_reg == HS_IDLE)
		begin
			qcnt_reg <= 7'h00;
			ph_reg   <= 2'h0;
			if (go_write || go_read)
			begin
				// address byte first, direction in lsb
				sh_reg    <= {ADDR_HI, pins_reg[HPIN_ASEL], ADDR_LSB, go_read};
				rd_reg    <= go_read;
				idx_reg   <= 2'h0;
				bitn_reg  <= 4'h0;
				nack_reg  <= 1'h0;
				busy_reg  <= 1'h1;
				state_reg <= HS_START;
			end
		end
		else
		begin
			qcnt_reg <= tick ? 7'h00 : qcnt_reg + 7'h01;
			if (tick)
			begin
				ph_reg <= ph_reg + 2'h1;
				case (state_reg)
					HS_START:
					begin
						sda_oe_reg <= ph_reg != 2'h0;
						scl_reg    <= ph_reg < 2'h2;
						if (ph_reg == 2'h3)
							state_reg <= HS_BIT;
					end
					HS_BIT:
					begin
						scl_reg <= (ph_reg == 2'h0) | (ph_reg == 2'h1);
						// ack read bytes except the last, which is nacked
						if (ph_reg == 2'h0)
							sda_oe_reg <= (bitn_reg == 4'h8) ? (rx_byte & ~last_idx) : (~rx_byte & ~sh_reg[7]);
						if (ph_reg == 2'h2 && bitn_reg != 4'h8 && rx_byte)
							rx_reg <= {rx_reg[14:0], sda_f_reg};
						if (ph_reg == 2'h2 && bitn_reg == 4'h8 && !rx_byte && sda_f_reg)
							nack_reg <= 1'h1;
						if (ph_reg == 2'h3 && bitn_reg != 4'h8)
						begin
							sh_reg   <= {sh_reg[6:0], 1'h0};
							bitn_reg <= bitn_reg + 4'h1;
						end
						else if (ph_reg == 2'h3)
						begin
							bitn_reg <= 4'h0;
							idx_reg  <= idx_reg + 2'h1;
							sh_reg   <= tx_next;
							if (last_idx || nack_reg)
								state_reg <= HS_STOP;
						end
					end
					default:
					begin
						// stop: data low, clock high, then release data
						sda_oe_reg <= ph_reg < 2'h2;
						scl_reg    <= ph_reg != 2'h0;
						if (ph_reg == 2'h3)
						begin
							busy_reg  <= 1'h0;
							state_reg <= HS_IDLE;
						end
					end
				endcase
			end
		end
	end

	// link pins straight from flops
	assign link.scl                = scl_reg;
	assign link.host_sda_o         = 1'h0;
	assign link.host_sda_oe        = sda_oe_reg;
	assign link.load_strobe_n      = load_n_reg;
	assign link.reset_n            = rst_n_reg;
	assign link.address_select_pin = asel_reg;
endmodule : dcu_host

`default_nettype wire

// File: sim/dac_control_and_update_logic_bench.sv
// Purpose: both ends joined, driven through the controller registers
// Assumes: about 12k cycles per link write
// Notes:   outputs packed as {span,ref,pair,driven,1k,100k,code}
`default_nettype none

module dac_control_and_update_logic_bench
	import dcu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i = 1'h0;
	logic        resetn_i  = 1'h0;
	logic [3:0]  addr_i    = 4'h0;
	logic [31:0] wdata_i   = 32'h0;
	logic        wr_i      = 1'h0;
	logic        rd_i      = 1'h0;
	logic [31:0] rdata_o;
	logic [15:0] code;
	logic        span;
	logic        ref_on;
	logic        hi;
	logic        lo;
	logic        drv;
	logic        l1k;
	logic        l100k;
	logic        valid;
	logic [31:0] got;
	int          fail_count = 0;
	int          n_checks   = 0;
	wire  [31:0] outs = {9'h000, span, ref_on, hi, lo, drv, l1k, l100k, code};

	always #4 sys_clk_i = ~sys_clk_i;

	dcu_if dcu_if_i();
	dcu_host dcu_host_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(dcu_if_i.host));
	// short exit count keeps any power-down exit brief
	dcu_device #(.EXIT_REF_CYC(600)) dcu_device_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.link(dcu_if_i.device), .analog_output_code_o(code), .span_x2_o(span), .ref_on_o(ref_on),
		.powerdown_sel_hi_o(hi), .powerdown_sel_lo_o(lo), .output_driven_o(drv), .load_1k_o(l1k),
		.load_100k_o(l100k), .output_valid_o(valid));
	dcu_checker dcu_checker_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reset_n(dcu_if_i.reset_n),
		.analog_output_code_o(code), .span_x2_o(span), .ref_on_o(ref_on), .powerdown_sel_hi_o(hi),
		.powerdown_sel_lo_o(lo), .output_driven_o(drv), .load_1k_o(l1k), .load_100k_o(l100k),
		.output_valid_o(valid));

	// register bus write, one cycle strobe
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'h1;
		@(posedge sys_clk_i);
		wr_i <= 1'h0;
		// idle edge so a following write never re-raises the strobe in the same step
		@(posedge sys_clk_i);
	endtask : wr

	// register bus read, data taken the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		addr_i <= a;
		rd_i   <= 1'h1;
		@(posedge sys_clk_i);
		rd_i <= 1'h0;
		@(posedge sys_clk_i);
		got = rdata_o;
	endtask : rd

	// link transfer, then poll busy under a bound
	task automatic xfer(input logic [7:0] c, input logic [15:0] d, input logic r);
		int n;
		n = 0;
		wr(HREG_DATA, {8'h00, c, d});
		wr(HREG_CTRL, r ? 32'h2 : 32'h1);
		repeat (4) @(posedge sys_clk_i);
		// reads pulse the strobe while addressed
		if (r)
		begin
			repeat (4000) @(posedge sys_clk_i);
			wr(HREG_PINS, 32'h0);
			wr(HREG_PINS, 32'h1);
		end
		do
		begin
			rd(HREG_STAT);
			n++;
		end
		while (got[0] !== 1'h0 && n < 20000);
		// a stuck transfer ends the run as a failure
		if (got[0] !== 1'h0)
		begin
			chk(32'h1, 32'h0);
			end_of_test();
		end
	endtask : xfer

	// value comparison
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic tdone;
		$display("test done at %0t", $time);
	endtask : tdone

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	// hang guard, only a little past the expected run
	initial
	begin
		#800000;
		fail_count++;
		end_of_test();
	end

	// main sequence
	initial
	begin
		repeat (16) @(posedge sys_clk_i);
		resetn_i <= 1'h1;
		repeat (8) @(posedge sys_clk_i);
		chk(outs, 32'h00240000);
		rd(HREG_PINS);
		chk(got, 32'h1);
		rd(4'h2);
		chk(got, 32'h0);
		tdone();
		xfer(8'h10, 16'h1234, 1'h0);
		chk(outs, 32'h00240000);
		xfer(8'h00, 16'h0000, 1'h1);
		chk({16'h0000, got[31:16]}, 32'h1234);
		chk(outs, 32'h00240000);
		xfer(8'h20, 16'hFFFF, 1'h0);
		chk(outs, 32'h00241234);
		xfer(8'h30, 16'hABCD, 1'h0);
		chk(outs, 32'h0024ABCD);
		tdone();
		xfer(8'h40, 16'h3800, 1'h0);
		chk(outs, 32'h004AABCD);
		chk({31'h00000000, valid}, 32'h0);
		wr(HREG_PINS, 32'h0);
		xfer(8'h10, 16'h0F0F, 1'h0);
		chk(outs, 32'h004A0F0F);
		xfer(8'h40, 16'h8000, 1'h0);
		chk(outs, 32'h00240000);
		tdone();
		wr(HREG_PINS, 32'h5);
		xfer(8'h10, 16'h7777, 1'h0);
		chk(outs, 32'h00240000);
		chk({31'h00000000, valid}, 32'h1);
		wr(HREG_PINS, 32'h4);
		repeat (10) @(posedge sys_clk_i);
		chk(outs, 32'h00247777);
		wr(HREG_CTRL, 32'h4);
		repeat (30) @(posedge sys_clk_i);
		chk(outs, 32'h00240000);
		tdone();
		end_of_test();
	end
endmodule : dac_control_and_update_logic_bench

`default_nettype wire

// File: sim/dcu_assertions.sv
// Purpose: checks on the target's outputs and reset pin
// Assumes: one clock domain, synchronous reset
// Notes:   pin filter lags four cycles, registers and outputs two more, hence seven-cycle holds
`default_nettype none

module dcu_checker
	import dcu_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        reset_n,
	input  wire logic [15:0] analog_output_code_o,
	input  wire logic        span_x2_o,
	input  wire logic        ref_on_o,
	input  wire logic        powerdown_sel_hi_o,
	input  wire logic        powerdown_sel_lo_o,
	input  wire logic        output_driven_o,
	input  wire logic        load_1k_o,
	input  wire logic        load_100k_o,
	input  wire logic        output_valid_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// power-down pair as one field
	wire logic [1:0] pair_w = {powerdown_sel_hi_o, powerdown_sel_lo_o};

	// reset pin low long enough to pass the filter
	sequence s_pin_held;
		!reset_n [*7];
	endsequence

	property p_driven;
		output_driven_o == (pair_w == PWDN_NORMAL);
	endproperty
	a_driven: assert property (p_driven) else $error("driven flag wrong");
	property p_load_1k;
		load_1k_o == (pair_w == PWDN_1K);
	endproperty
	a_load_1k: assert property (p_load_1k) else $error("1k load flag wrong");
	property p_load_100k;
		load_100k_o == (pair_w == PWDN_100K);
	endproperty
	a_load_100k: assert property (p_load_100k) else $error("100k load flag wrong");
	property p_pin_code;
		s_pin_held |-> analog_output_code_o == CODE_RST && pair_w == PWDN_RST && span_x2_o == GAIN_RST;
	endproperty
	a_pin_code: assert property (p_pin_code) else $error("reset pin left state");
	property p_pin_ref;
		s_pin_held |-> !ref_on_o;
	endproperty
	a_pin_ref: assert property (p_pin_ref) else $error("reference on in reset");
	property p_pd_keep;
		$changed(pair_w) && pair_w != PWDN_NORMAL |-> $stable(analog_output_code_o);
	endproperty
	a_pd_keep: assert property (p_pd_keep) else $error("code moved on power-down");
	property p_pd_valid;
		pair_w != PWDN_NORMAL |=> !output_valid_o;
	endproperty
	a_pd_valid: assert property (p_pd_valid) else $error("valid in power-down");
	property p_hold_zero;
		$rose(reset_n) |-> (analog_output_code_o == CODE_RST) [*8];
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("code left zero");
endmodule : dcu_checker

`default_nettype wire
